//--- logic/bwde_pkg.sv
package bwde_pkg;
    // Register byte offsets
    localparam logic [7:0] BWDE_OFF_BER    = 8'h00; // bus error register
    localparam logic [7:0] BWDE_OFF_MASK   = 8'h04; // interrupt enable mask
    localparam logic [7:0] BWDE_OFF_CNR    = 8'h08; // node configuration register
    localparam logic [7:0] BWDE_OFF_FADR   = 8'h0C; // failing address register
    localparam logic [7:0] BWDE_OFF_SYN0   = 8'h10; // syndrome registers 0..3
    localparam logic [7:0] BWDE_OFF_SYN3   = 8'h1C;

    // Bus error register fields
    localparam int BWDE_BER_UDE  = 0;
    localparam int BWDE_BER_CORRECTABLE_WRITE_ERROR = 1;
    localparam int BWDE_BER_TRANSMITTED_BAD_DATA_FLAG = 2;
    localparam int BWDE_BER_DSV  = 4; // syndrome valid bits 7:4

    // Configuration register fields
    localparam int BWDE_CNR_CORRECTABLE_WRITE_REPORT_DISABLE = 0; // correctable write report disable
    localparam int BWDE_CNR_CAPT = 1; // sharer captures and checks data

    // Syndrome register fields
    localparam int BWDE_SYN_TCE = 8;

    // Values after reset
    localparam logic [2:0] BWDE_MASK_RST = 3'h0;
    localparam logic [1:0] BWDE_CNR_RST  = 2'h0;

    // Data beats per write transfer
    localparam logic [1:0] BWDE_DATA_BEATS = 2'h2;

    // Error priority levels
    localparam logic [1:0] BWDE_PRIO_NONE = 2'h0;
    localparam logic [1:0] BWDE_PRIO_CORRECTABLE_WRITE_ERROR = 2'h1;
    localparam logic [1:0] BWDE_PRIO_UDE  = 2'h2;

    // Transfer sequencer states
    typedef enum logic [1:0] {
        BWDE_IDLE = 2'b00,
        BWDE_ACK  = 2'b01,
        BWDE_DATA = 2'b11,
        BWDE_DONE = 2'b10
    } bwde_state_t;
endpackage

//--- logic/bwde_top.sv
`timescale 1ns/1ns
// What this block does
// - As the addressed memory slave of a write, acknowledge the command, time the data beats and store the data.
// - As a bystander node, look up the written block in the cache and assert the shared line on a hit.
// - A sharing node either captures and checks the write data or invalidates its copy of the block.
// - A node receiving write data with an error asserts the bus data-error line.
// - A commander seeing the data-error line on its write sets the transmitted-bad-data flag and tells the requester.
// - A single-bit write error sets the correctable flag; memory still stores the data and latches the address.
// - A multi-bit write error sets the uncorrectable flag; memory still stores the data and latches the address.
// - Syndrome-valid bits in the bus error register tell which of four syndrome registers hold the error status.
// - The transmit-check flag in a syndrome register is set when the node's own driven data failed its check.
// - With the disable bit set, correctable write errors do not assert the data-error line.
// - With the disable bit set, the commander does not interrupt the requester for correctable write errors.
// - The disable bit never stops detection; the correctable flag still sets for polling.
// - An uncorrectable error overwrites status and always interrupts; that interrupt cannot be masked.
// - Status is overwritten only by a higher priority error; among equals the first is kept.
module bwde_top (
    input  wire logic        pclk,            // Bus clock
    input  wire logic        presetn,         // Async reset, active low
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB access phase
    input  wire logic        pwrite,          // APB direction
    input  wire logic [7:0]  paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic [31:0]      prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error on unmapped
    input  wire logic        cmd_valid,       // Command cycle on the bus
    input  wire logic        cmd_write,       // Command is a write
    input  wire logic [31:0] cmd_addr,        // Command address
    input  wire logic        cmd_mine,        // This node is the commander
    input  wire logic        mem_hit,         // Address maps to this memory
    input  wire logic        cache_hit,       // Cache holds the block
    input  wire logic        bus_data_valid,  // Write data beat on the bus
    input  wire logic        ecc_single,      // Beat has a single-bit error
    input  wire logic        ecc_multi,       // Beat has a multi-bit error
    input  wire logic [1:0]  ecc_lane,        // Lane of the checked quadword
    input  wire logic [7:0]  ecc_syndrome,    // Syndrome of the beat
    input  wire logic        tx_check_fail,   // Own transmit check failed
    input  wire logic        bus_data_error_line, // Data-error line sensed
    output logic             bus_data_error_out,  // Drive data-error line
    output logic             shared_block_line,   // Drive shared line
    output logic             cmd_ack,         // Slave acknowledge pulse
    output logic             data_cycle,      // Slave data timing
    output logic             store_write,     // Store beat into memory
    output logic             invalidate_block,// Drop cached copy
    output logic             irq              // Requester interrupt
);
    import bwde_pkg::*;

    bwde_state_t state;
    bwde_state_t next_state;
    logic [1:0]  beat_cnt;
    logic        role_cmdr;
    logic        role_slave;
    logic        role_share;
    logic [31:0] cur_addr;
    logic [2:0]  flags;
    logic [3:0]  syn_valid;
    logic [8:0]  syn_reg [4];
    logic [31:0] fail_addr;
    logic [1:0]  held_prio;
    logic [2:0]  mask;
    logic [1:0]  cnr;

    // APB decode
    wire         apb_done  = psel & penable & pready;
    wire         apb_wr    = apb_done & pwrite;
    wire         apb_rd    = apb_done & ~pwrite;
    wire         hit_ber   = paddr == BWDE_OFF_BER;
    wire         hit_mask  = paddr == BWDE_OFF_MASK;
    wire         hit_cnr   = paddr == BWDE_OFF_CNR;
    wire         hit_fadr  = paddr == BWDE_OFF_FADR;
    wire         hit_syn   = paddr >= BWDE_OFF_SYN0 && paddr <= BWDE_OFF_SYN3 && paddr[1:0] == 2'h0;
    wire         mapped    = hit_ber | hit_mask | hit_cnr | hit_fadr | hit_syn;
    wire         ber_clear = apb_rd & hit_ber;
    wire         correctable_write_report_disable      = cnr[BWDE_CNR_CORRECTABLE_WRITE_REPORT_DISABLE];
    wire         capture   = cnr[BWDE_CNR_CAPT];

    // Read data selection
    wire [31:0]  ber_word  = {24'h0, syn_valid, 1'b0, flags};
    wire [31:0]  syn_word  = {23'h0, syn_reg[paddr[3:2]]};
    wire [31:0]  rd_mux    = hit_ber  ? ber_word :
                             hit_mask ? {29'h0, mask} :
                             hit_cnr  ? {30'h0, cnr} :
                             hit_fadr ? fail_addr :
                             hit_syn  ? syn_word : 32'h0;

    // Bus role and beat checking
    wire         start     = cmd_valid & cmd_write;
    wire         chk_node  = role_cmdr | role_slave | (role_share & capture);
    wire         receiver  = role_slave | (role_share & capture);
    wire         beat      = (state == BWDE_DATA) & bus_data_valid;
    wire         chk_beat  = beat & chk_node;
    wire         is_ude    = chk_beat & ecc_multi;
    wire         is_cw     = chk_beat & ecc_single & ~ecc_multi;
    wire [1:0]   new_prio  = is_ude ? BWDE_PRIO_UDE : is_cw ? BWDE_PRIO_CORRECTABLE_WRITE_ERROR : BWDE_PRIO_NONE;
    wire [1:0]   base_prio = ber_clear ? BWDE_PRIO_NONE : held_prio;
    wire         overwrite = new_prio > base_prio;
    wire         tce_now   = role_cmdr & tx_check_fail;
    wire         transmitted_bad_data_flag_set  = role_cmdr & bus_data_error_line &
                             (state == BWDE_DATA || state == BWDE_DONE);
    wire         err_drive = beat & receiver & (ecc_multi | (ecc_single & ~correctable_write_report_disable));
    wire [2:0]   flag_set  = {transmitted_bad_data_flag_set, is_cw, is_ude};
    wire [2:0]   irq_en    = {mask[BWDE_BER_TRANSMITTED_BAD_DATA_FLAG], mask[BWDE_BER_CORRECTABLE_WRITE_ERROR] & ~correctable_write_report_disable, 1'b1};
    wire [3:0]   lane_hot  = 4'h1 << ecc_lane;

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            BWDE_IDLE: begin
                if (start) begin
                    next_state = BWDE_ACK;
                end
            end
            BWDE_ACK: begin
                next_state = BWDE_DATA;
            end
            BWDE_DATA: begin
                if (beat && beat_cnt == BWDE_DATA_BEATS - 2'h1) begin
                    next_state = BWDE_DONE;
                end
            end
            BWDE_DONE: begin
                next_state = BWDE_IDLE;
            end
            default: begin
                next_state = BWDE_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= BWDE_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Roles and beat count, latched with the command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            beat_cnt   <= 2'h0;
            role_cmdr  <= 1'b0;
            role_slave <= 1'b0;
            role_share <= 1'b0;
            cur_addr   <= 32'h0;
        end else begin
            if (state == BWDE_IDLE && start) begin
                role_cmdr  <= cmd_mine;
                role_slave <= mem_hit & ~cmd_mine;
                role_share <= cache_hit & ~cmd_mine & ~mem_hit;
                cur_addr   <= cmd_addr;
                beat_cnt   <= 2'h0;
            end else if (beat) begin
                beat_cnt <= beat_cnt + 2'h1;
            end
        end
    end

    // Next values of the bus-side outputs
    wire         next_cmd_ack    = state == BWDE_IDLE && start && mem_hit && !cmd_mine;
    wire         next_data_cycle = role_slave && next_state == BWDE_DATA;
    wire         next_store      = beat & role_slave;
    wire         next_shared     = state == BWDE_IDLE && start && cache_hit && !cmd_mine && !mem_hit;
    wire         next_invalidate = state == BWDE_DONE && role_share && !capture;

    // Slave acknowledge pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ack <= 1'b0;
        end else begin
            cmd_ack <= next_cmd_ack;
        end
    end

    // Slave data timing, high through the beats
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_cycle <= 1'b0;
        end else begin
            data_cycle <= next_data_cycle;
        end
    end

    // Store strobe, also for faulty beats
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_write <= 1'b0;
        end else begin
            store_write <= next_store;
        end
    end

    // Shared line on a cache hit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_block_line <= 1'b0;
        end else begin
            shared_block_line <= next_shared;
        end
    end

    // Drop the copy when not checking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            invalidate_block <= 1'b0;
        end else begin
            invalidate_block <= next_invalidate;
        end
    end

    // Data-error line drive, one cycle per bad beat
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_data_error_out <= 1'b0;
        end else begin
            bus_data_error_out <= err_drive;
        end
    end

    // Sticky flags, syndrome and failing address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags     <= 3'h0;
            syn_valid <= 4'h0;
            held_prio <= BWDE_PRIO_NONE;
            fail_addr <= 32'h0;
            for (int i = 0; i < 4; i++) begin
                syn_reg[i] <= 9'h0;
            end
        end else begin
            flags <= (ber_clear ? 3'h0 : flags) | flag_set;
            if (overwrite) begin
                held_prio         <= new_prio;
                syn_valid         <= lane_hot;
                syn_reg[ecc_lane] <= {tce_now, ecc_syndrome};
                if (role_slave) begin
                    fail_addr <= cur_addr;
                end
            end else if (ber_clear) begin
                held_prio <= BWDE_PRIO_NONE;
                syn_valid <= 4'h0;
            end
        end
    end

    // Interrupt mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= BWDE_MASK_RST;
        end else if (apb_wr && hit_mask) begin
            mask <= pwdata[2:0];
        end
    end

    // Node configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnr <= BWDE_CNR_RST;
        end else if (apb_wr && hit_cnr) begin
            cnr <= pwdata[1:0];
        end
    end

    // First access cycle, answered at the next edge
    wire         acc_first   = psel & penable & ~pready;
    wire [31:0]  next_prdata = (acc_first & ~pwrite) ? rd_mux : 32'h0;

    // APB ready after one wait cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= acc_first;
        end
    end

    // Read data, zero outside the answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else begin
            prdata <= next_prdata;
        end
    end

    // Error answer on unmapped places
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= acc_first & ~mapped;
        end
    end

    // Interrupt from flags, uncorrectable never masked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & irq_en);
        end
    end
endmodule

//--- sim/bwde_properties.sv
`timescale 1ns/1ns
module bwde_properties (
    input wire logic pclk,               // Clock
    input wire logic presetn,            // Reset
    input wire logic cmd_valid,          // Command
    input wire logic cmd_write,          // Write
    input wire logic cmd_mine,           // Commander
    input wire logic mem_hit,            // Memory
    input wire logic cache_hit,          // Cache
    input wire logic bus_data_valid,     // Beat
    input wire logic ecc_single,         // Single
    input wire logic ecc_multi,          // Multi
    input wire logic bus_data_error_out, // Error drive
    input wire logic shared_block_line,  // Shared
    input wire logic cmd_ack,            // Ack
    input wire logic data_cycle,         // Timing
    input wire logic store_write,        // Store
    input wire logic invalidate_block,   // Drop copy
    input wire logic irq                 // Interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Slave answers only its own write command
    property p_ack; cmd_ack |-> $past(cmd_valid && cmd_write && mem_hit && !cmd_mine); endproperty
    a_ack: assert property (p_ack) else $error("ack without slave write");
    property p_timing; cmd_ack |-> ##[0:1] data_cycle; endproperty
    a_timing: assert property (p_timing) else $error("no data timing after ack");
    property p_store; store_write |-> $past(bus_data_valid && !cmd_mine); endproperty
    a_store: assert property (p_store) else $error("store without beat");
    // Error line only from a faulty received beat
    property p_errsrc; bus_data_error_out |-> $past(bus_data_valid && (ecc_single || ecc_multi)); endproperty
    a_errsrc: assert property (p_errsrc) else $error("error line without fault");
    property p_cmdr; bus_data_valid && cmd_mine |=> !bus_data_error_out; endproperty
    a_cmdr: assert property (p_cmdr) else $error("commander drove error line");
    property p_shr; shared_block_line |-> $past(cmd_valid && cmd_write && cache_hit && !cmd_mine); endproperty
    a_shr: assert property (p_shr) else $error("shared without cache hit");
    // Multi-bit fault interrupts whatever the mask
    property p_multi; bus_data_valid && ecc_multi && data_cycle |-> ##2 irq; endproperty
    a_multi: assert property (p_multi) else $error("no interrupt on multi fault");
    property p_inv; invalidate_block |-> cache_hit && !mem_hit && !cmd_mine; endproperty
    a_inv: assert property (p_inv) else $error("drop by wrong node");
    c_err: cover property (bus_data_error_out);
    c_irq: cover property (irq);
    c_inv: cover property (invalidate_block);
endmodule
bind bwde_top bwde_properties u_props (.pclk, .presetn, .cmd_valid, .cmd_write, .cmd_mine, .mem_hit,
    .cache_hit, .bus_data_valid, .ecc_single, .ecc_multi, .bus_data_error_out, .shared_block_line,
    .cmd_ack, .data_cycle, .store_write, .invalidate_block, .irq);

//--- sim/bwde_bus_model.sv
`timescale 1ns/1ns
module bwde_bus_model #(
    parameter logic [31:0] ADDR = 32'h00001240
) (
    input  wire logic        pclk,                // Clock
    input  wire logic        presetn,             // Reset
    input  wire logic        start,               // Launch a write
    input  wire logic [2:0]  role,                // Mine, memory, cache
    input  wire logic [3:0]  cls,                 // Fault class per beat
    input  wire logic [3:0]  lanes,               // Lane per beat
    input  wire logic [1:0]  flt,                 // Tx fault, line error
    output logic             cmd_valid,           // Command
    output logic             cmd_write,           // Write
    output logic [31:0]      cmd_addr,            // Address
    output logic             cmd_mine,            // Commander
    output logic             mem_hit,             // Memory
    output logic             cache_hit,           // Cache
    output logic             bus_data_valid,      // Beat
    output logic             ecc_single,          // Single
    output logic             ecc_multi,           // Multi
    output logic [1:0]       ecc_lane,            // Lane
    output logic [7:0]       ecc_syndrome,        // Syndrome
    output logic             tx_check_fail,       // Own check
    output logic             bus_data_error_line  // Other receivers
);
    logic [2:0] step;
    logic       b1;
    // Transfer steps after launch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) step <= 3'h0;
        else if (start) step <= 3'h1;
        else if (step != 3'h0) step <= step + 3'h1;
    end
    // Command in step 1, two beats in steps 3 and 4
    assign b1 = (step == 3'h4);
    assign cmd_valid = (step == 3'h1);
    assign cmd_write = cmd_valid;
    assign cmd_addr = cmd_valid ? ADDR : ~ADDR; // Released address inverted
    assign {cmd_mine, mem_hit, cache_hit} = role;
    assign bus_data_valid = (step == 3'h3) || b1;
    assign ecc_single = bus_data_valid && (b1 ? cls[2] : cls[0]);
    assign ecc_multi = bus_data_valid && (b1 ? cls[3] : cls[1]);
    assign ecc_lane = b1 ? lanes[3:2] : lanes[1:0];
    assign ecc_syndrome = bus_data_valid ? (b1 ? 8'h3C : 8'hA5) : {5'h1F, step};
    assign tx_check_fail = (step == 3'h3) && flt[1];
    // Another receiver flags the commander's data
    assign bus_data_error_line = flt[0] && (b1 || step == 3'h5);
endmodule

//--- sim/bus_write_data_error_handling_tb.sv
`timescale 1ns/1ns
module bus_write_data_error_handling_tb;
    import bwde_pkg::*;
    localparam logic [31:0] WADDR = 32'h00001240;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, cmd_addr;
    logic [2:0]  role = 3'h0;
    logic [3:0]  cls = 4'h0, lanes = 4'h0;
    logic [1:0]  flt = 2'h0, ecc_lane;
    logic [7:0]  ecc_syndrome;
    logic        pready, pslverr, sl, cmd_valid, cmd_write, cmd_mine, mem_hit, cache_hit, bus_data_valid;
    logic        ecc_single, ecc_multi, tx_check_fail, bus_data_error_line, bus_data_error_out;
    logic        shared_block_line, cmd_ack, data_cycle, store_write, invalidate_block, irq;
    int          err_total = 0, num_checks = 0, cyc = 0, n_err, n_st, n_ack, n_shr, n_inv;
    bwde_top DUT (.*);
    bwde_bus_model #(.ADDR(WADDR)) u_bus (.*);
    always #25 pclk = ~pclk;
    // Pulse counters and hang guard
    always @(posedge pclk) begin
        cyc++;
        n_err += bus_data_error_out;
        n_st += store_write;
        n_ack += cmd_ack;
        n_shr += shared_block_line;
        n_inv += invalidate_block;
        if (cyc == 4000) begin
            err_total++;
            print_verdict();
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One whole write transfer on the shared bus
    task op(input logic [2:0] r, input logic [3:0] c, input logic [3:0] l, input logic [1:0] f);
        @(posedge pclk);
        {role, cls, lanes, flt} <= {r, c, l, f};
        start <= 1'b1;
        {n_err, n_st, n_ack, n_shr, n_inv} = '0;
        @(posedge pclk);
        start <= 1'b0;
        repeat (10) @(posedge pclk);
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped place
        apb(1'b0, BWDE_OFF_CNR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(sl), 32'h1);
        // Slave write: single fault lane 1, then multi fault lane 2
        op(3'b010, 4'b1001, 4'b1001, 2'b00);
        chk(n_ack, 32'h1);
        chk(n_st, 32'h2);
        chk(n_err, 32'h2);
        chk(32'(irq), 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h3C);
        apb(1'b0, BWDE_OFF_FADR, 32'h0);
        chk(rd, WADDR);
        apb(1'b0, BWDE_OFF_BER, 32'h0);
        chk(rd, 32'h43);
        // Correctable reporting off, two equal faults
        apb(1'b1, BWDE_OFF_CNR, 32'h1);
        apb(1'b1, BWDE_OFF_MASK, 32'h7);
        op(3'b010, 4'b0101, 4'b1100, 2'b00);
        chk(n_err, 32'h0);
        chk(32'(irq), 32'h0);
        apb(1'b0, BWDE_OFF_SYN0, 32'h0);
        chk(rd, 32'hA5);
        apb(1'b0, BWDE_OFF_BER, 32'h0);
        chk(rd, 32'h12);
        // Commander with own transmit fault and flagged data
        apb(1'b1, BWDE_OFF_CNR, 32'h0);
        op(3'b100, 4'b0001, 4'b0011, 2'b11);
        chk(n_err, 32'h0);
        chk(32'(irq), 32'h1);
        apb(1'b0, BWDE_OFF_SYN3, 32'h0);
        chk(rd, 32'h1A5);
        apb(1'b0, BWDE_OFF_BER, 32'h0);
        chk(rd, 32'h86);
        // Sharer that checks, then sharer that drops its copy
        apb(1'b1, BWDE_OFF_CNR, 32'h2);
        op(3'b001, 4'b1000, 4'b0000, 2'b00);
        chk(n_shr, 32'h1);
        chk(n_err, 32'h1);
        apb(1'b1, BWDE_OFF_CNR, 32'h0);
        op(3'b001, 4'b0000, 4'b0000, 2'b00);
        chk(n_inv, 32'h1);
        print_verdict();
    end
endmodule
